// *** dpwe_top.sv ***
// Direction pulse width encoder: turns switching events into low pulses on an open-drain line.
// Assumes switch events arrive asynchronously and a pull-up makes the line high when released.
// Notes on behaviour
// - A speed-only mode gives a fixed pulse with no direction content.
// - In direction modes the direction is carried only by the pulse width, from one of four sets.
// - Each pulse is a low level from falling edge to the next rising edge of the line.
// - Forward pulse is 45 us in sets one, two and four and 60 us in set three.
// - Backward pulse is 135, 180, 120 or 90 us for sets one to four.
// - With high speed chosen, the high-speed pulse is 30 us in sets one and three, 45 us in two and four.
// - In set one with stand-still enabled, a 60 us pulse follows 50 ms without a switching event.
// - In set two the first pulse after a magnetic edge is suppressed.
// - For about 0.9 ms after power-up the output stays high and no pulse is made.
// - A two-bit width_set_select picks set one to four for 00 to 11, with 11 as default.
// - Stand-still pulses occur only when enabled and width_set_select is 00.
// - With high speed chosen, high-speed pulses are used once the event rate exceeds 4.3 kHz.
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module dpwe_top #(
    parameter int unsigned PWRON_CYC = dpwe_pkg::CYC_PWRON,
    parameter int unsigned STILL_CYC = dpwe_pkg::CYC_STILL_GAP,
    parameter int unsigned HS_CYC = dpwe_pkg::CYC_HS_PERIOD
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Magnetic switching events from the analog front end
    input wire logic sw_event,
    input wire logic sw_dir_bwd,
    input wire logic sw_edge_first,
    // Open-drain output line
    output logic q_o,
    output logic q_oe,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    initial begin
        if (PWRON_CYC < 1 || STILL_CYC < 2 || HS_CYC < 2 || PWRON_CYC >= 2**24 || STILL_CYC >= 2**24)
            $error("dpwe_top: timing parameters out of range");
    end

    // Input synchronisers
    logic [2:0] sync1_q, sync2_q, sync3_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sync3_q <= 3'h0;
        end else begin
            sync1_q <= {sw_edge_first, sw_dir_bwd, sw_event};
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    logic ev_pulse;
    assign ev_pulse = sync2_q[0] && !sync3_q[0];

    // Register bus
    logic [5:0] ctrl_q, ctrl_d;
    logic [15:0] evt_cnt_q, evt_cnt_d;
    logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] stat_word;
    dpwe_pkg::dpwe_state_t st_q, st_d;
    logic hs_active_q, hs_active_d, emitted_q;
    logic [1:0] wsel;
    assign wsel = ctrl_q[dpwe_pkg::CTRL_WSEL_LSB +: 2];

    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign stat_word = {28'h0, emitted_q, hs_active_q, st_q == dpwe_pkg::ST_PULSE,
                        st_q == dpwe_pkg::ST_PWRON};

    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d = w_got_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        ctrl_d = ctrl_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (aw_got_q && w_got_q) begin
            aw_got_d = 1'b0;
            w_got_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = 2'h0;
            if (awaddr_q[3:2] == dpwe_pkg::ADDR_CTRL[3:2]) begin
                if (wstrb_q[0])
                    ctrl_d = wdata_q[5:0];
            end else if (awaddr_q[3:2] == dpwe_pkg::ADDR_STAT[3:2]
                         || awaddr_q[3:2] == dpwe_pkg::ADDR_EVT[3:2]) begin
                bresp_d = 2'h0;
            end else begin
                bresp_d = 2'h2;
            end
        end
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = 2'h0;
            if (s_axi_araddr[3:2] == dpwe_pkg::ADDR_CTRL[3:2]) begin
                rdata_d = {26'h0, ctrl_q};
            end else if (s_axi_araddr[3:2] == dpwe_pkg::ADDR_STAT[3:2]) begin
                rdata_d = stat_word;
            end else if (s_axi_araddr[3:2] == dpwe_pkg::ADDR_EVT[3:2]) begin
                rdata_d = {16'h0, evt_cnt_q};
            end else begin
                rdata_d = 32'h0;
                rresp_d = 2'h2;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= 2'h0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= 2'h0;
            ctrl_q <= dpwe_pkg::CTRL_RESET;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            ctrl_q <= ctrl_d;
        end
    end

    // Pulse engine
    logic [23:0] cnt_q, cnt_d, gap_q, gap_d;
    logic [15:0] width_cyc;
    logic [2:0] kind, kind_q, kind_d;
    logic pon_done_q, pon_done_d, low_q, low_d, emitted_d;
    logic bwd, still_due, fire, suppress;
    assign bwd = sync2_q[1] ^ ctrl_q[dpwe_pkg::CTRL_FWD_INV];
    // Stand-still only in set one and when enabled
    assign still_due = ctrl_q[dpwe_pkg::CTRL_STILL_EN] && wsel == 2'h0
                       && gap_q >= 24'(STILL_CYC - 1);
    assign suppress = wsel == 2'h1 && sync2_q[2];
    assign fire = ev_pulse && !suppress;

    dpwe_width_lut u_lut (
        .wset(wsel),
        .kind(kind_q),
        .width_cyc(width_cyc)
    );

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        low_d = low_q;
        kind_d = kind_q;
        pon_done_d = pon_done_q;
        hs_active_d = hs_active_q;
        emitted_d = 1'b0;
        evt_cnt_d = evt_cnt_q;
        gap_d = (gap_q == 24'hffffff) ? gap_q : gap_q + 24'h1;
        kind = 3'h0;
        if (ev_pulse) begin
            gap_d = 24'h0;
            // Edge spacing measured between events sets the high-speed state
            hs_active_d = ctrl_q[dpwe_pkg::CTRL_HS_EN] && gap_q < 24'(HS_CYC);
            evt_cnt_d = evt_cnt_q + 16'h1;
        end
        if (!ctrl_q[dpwe_pkg::CTRL_DIR_EN])
            kind = 3'h5;
        else if (hs_active_q && ctrl_q[dpwe_pkg::CTRL_HS_EN])
            kind = 3'h2;
        else
            kind = bwd ? 3'h1 : 3'h0;
        case (st_q)
            dpwe_pkg::ST_PWRON: begin
                cnt_d = cnt_q + 24'h1;
                if (cnt_q >= 24'(PWRON_CYC - 1)) begin
                    cnt_d = 24'h0;
                    if (wsel != 2'h1) begin
                        kind_d = 3'h4;
                        low_d = 1'b1;
                        emitted_d = 1'b1;
                        st_d = dpwe_pkg::ST_PULSE;
                    end else begin
                        st_d = dpwe_pkg::ST_IDLE;
                    end
                    pon_done_d = 1'b1;
                end
            end
            dpwe_pkg::ST_IDLE: begin
                if (fire || still_due) begin
                    kind_d = fire ? kind : 3'h3;
                    cnt_d = 24'h0;
                    low_d = 1'b1;
                    emitted_d = 1'b1;
                    st_d = dpwe_pkg::ST_PULSE;
                    if (still_due)
                        gap_d = 24'h0;
                end
            end
            default: begin
                cnt_d = cnt_q + 24'h1;
                if (cnt_q >= {8'h0, width_cyc} - 24'h1) begin
                    low_d = 1'b0;
                    cnt_d = 24'h0;
                    st_d = dpwe_pkg::ST_IDLE;
                    // Stand-still timer restarts when its pulse ends, else short gaps repeat at once
                    if (kind_q == 3'h3)
                        gap_d = 24'h0;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= dpwe_pkg::ST_PWRON;
            cnt_q <= 24'h0;
            gap_q <= 24'h0;
            low_q <= 1'b0;
            kind_q <= 3'h0;
            pon_done_q <= 1'b0;
            hs_active_q <= 1'b0;
            emitted_q <= 1'b0;
            evt_cnt_q <= 16'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            gap_q <= gap_d;
            low_q <= low_d;
            kind_q <= kind_d;
            pon_done_q <= pon_done_d;
            hs_active_q <= hs_active_d;
            emitted_q <= emitted_d;
            evt_cnt_q <= evt_cnt_d;
        end
    end

    // Open drain: pull low while pulsing, release otherwise
    assign q_o = 1'b0;
    assign q_oe = low_q;

    chk_pwron_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == dpwe_pkg::ST_PWRON |-> !q_oe) else $error("line driven during power-on");
    chk_pulse_width: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(q_oe) |-> q_oe throughout ##1 (st_q == dpwe_pkg::ST_PULSE)[*2])
        else $error("pulse too short");
    chk_set2_no_pon: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == dpwe_pkg::ST_PWRON && st_d != st_q && wsel == 2'h1) |=> !q_oe)
        else $error("power-on pulse in set two");
    chk_set2_suppr: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == dpwe_pkg::ST_IDLE && ev_pulse && suppress && !still_due) |=> !q_oe)
        else $error("first edge pulse not suppressed");
    chk_still_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == dpwe_pkg::ST_IDLE && kind_d == 3'h3 && st_d == dpwe_pkg::ST_PULSE)
        |-> wsel == 2'h0 && ctrl_q[dpwe_pkg::CTRL_STILL_EN]) else $error("bad stand-still");
    chk_speed_only: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == dpwe_pkg::ST_IDLE && fire && !ctrl_q[dpwe_pkg::CTRL_DIR_EN]) |=> kind_q == 3'h5)
        else $error("speed-only width not used");
    chk_hs_kind: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == dpwe_pkg::ST_IDLE && fire && ctrl_q[2] && hs_active_q && ctrl_q[3])
        |=> kind_q == 3'h2) else $error("high-speed width not used");
    chk_dir_kind: assert property (@(posedge aclk) disable iff (!aresetn)
        (st_q == dpwe_pkg::ST_IDLE && fire && ctrl_q[2] && !hs_active_q)
        |=> kind_q == {2'b00, $past(bwd)}) else $error("direction width wrong");
endmodule

// *** dpwe_pkg.sv ***
// Package for the direction pulse width encoder: timing, register map, field layout.
// Assumes a 250 MHz aclk; power-on, stand-still and high-speed times are converted to cycle counts here, pulse widths in the width lookup.
package dpwe_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // Pulse widths in microseconds, typical, then power-on time, stand-still gap in ms and high-speed rate in Hz
    localparam int unsigned T_FWD_US = 45;
    localparam int unsigned T_FWD3_US = 60;
    localparam int unsigned T_BWD1_US = 135;
    localparam int unsigned T_BWD2_US = 180;
    localparam int unsigned T_BWD3_US = 120;
    localparam int unsigned T_BWD4_US = 90;
    localparam int unsigned T_HS13_US = 30;
    localparam int unsigned T_HS24_US = 45;
    localparam int unsigned T_STILL_US = 60;
    localparam int unsigned T_PON14_US = 180;
    localparam int unsigned T_PON3_US = 30;
    localparam int unsigned T_SPEED_US = 45;
    localparam int unsigned T_PWRON_US = 900;
    localparam int unsigned T_STILL_GAP_MS = 50;
    localparam int unsigned T_HS_FREQ_HZ = 4300;
    localparam int unsigned CYC_PER_US = CLK_MHZ;
    localparam int unsigned CYC_PWRON = T_PWRON_US * CYC_PER_US;
    localparam int unsigned CYC_STILL_GAP = T_STILL_GAP_MS * 1000 * CYC_PER_US;
    // Edge spacing below this means above the high-speed frequency
    localparam int unsigned CYC_HS_PERIOD = (CLK_MHZ * 1000000) / T_HS_FREQ_HZ;
    localparam int unsigned PW_W = 16;
    // Register map, byte addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_EVT = 4'h8;
    // Control field positions
    localparam int unsigned CTRL_WSEL_LSB = 0;
    localparam int unsigned CTRL_DIR_EN = 2;
    localparam int unsigned CTRL_HS_EN = 3;
    localparam int unsigned CTRL_STILL_EN = 4;
    localparam int unsigned CTRL_FWD_INV = 5;
    localparam logic [5:0] CTRL_RESET = 6'h07;
    typedef enum logic [1:0] {WSET1, WSET2, WSET3, WSET4} dpwe_wset_t;
    typedef enum {ST_PWRON, ST_IDLE, ST_PULSE} dpwe_state_t;
endpackage

// *** dpwe_width_lut.sv ***
// Width lookup: picks the pulse width in cycles for a set and pulse kind.
// Assumes kind codes as listed below; combinational only.
`timescale 1ns/1ps
module dpwe_width_lut (
    // Selection
    input wire logic [1:0] wset,
    input wire logic [2:0] kind,
    // Result
    output logic [dpwe_pkg::PW_W-1:0] width_cyc
);
    // kind: 0 fwd, 1 bwd, 2 high speed, 3 stand-still, 4 power-on, 5 speed only
    logic [31:0] us;
    always_comb begin
        us = 32'h0;
        case (kind)
            3'h0: us = (wset == 2'h2) ? dpwe_pkg::T_FWD3_US : dpwe_pkg::T_FWD_US;
            3'h1: begin
                case (wset)
                    2'h0: us = dpwe_pkg::T_BWD1_US;
                    2'h1: us = dpwe_pkg::T_BWD2_US;
                    2'h2: us = dpwe_pkg::T_BWD3_US;
                    default: us = dpwe_pkg::T_BWD4_US;
                endcase
            end
            3'h2: us = wset[0] ? dpwe_pkg::T_HS24_US : dpwe_pkg::T_HS13_US;
            3'h3: us = dpwe_pkg::T_STILL_US;
            3'h4: us = (wset == 2'h2) ? dpwe_pkg::T_PON3_US : dpwe_pkg::T_PON14_US;
            default: us = dpwe_pkg::T_SPEED_US;
        endcase
    end
    assign width_cyc = dpwe_pkg::PW_W'(us * dpwe_pkg::CYC_PER_US);
endmodule

// *** dpwe_tcu_model.sv ***
// Control unit model: watches the open-drain output line and times low pulses.
// Assumes a pull-up on the line and the same aclk as the encoder.
`timescale 1ns/1ps
module dpwe_tcu_model (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Open-drain pin of the encoder
    input wire logic q_o,
    input wire logic q_oe,
    // Measurement
    output logic line,
    output int unsigned last_width,
    output int unsigned n_pulses
);
    int unsigned cnt;
    // Pull-up wins whenever the encoder lets go
    assign line = q_oe ? q_o : 1'b1;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 0;
            last_width <= 0;
            n_pulses <= 0;
        end else if (line !== 1'b1) begin
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            last_width <= cnt;
            n_pulses <= n_pulses + 1;
            cnt <= 0;
        end
    end
endmodule

// *** tb.sv ***
// Testbench of the pulse encoder: register setup, switching events, pulse widths.
// Assumes shortened power-on, stand-still and high-speed counts set below.
`timescale 1ns/1ps
module tb;
    logic aclk, aresetn, sw_event, sw_dir_bwd, sw_edge_first, q_o, q_oe, line;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic [1:0] bresp, rresp;
    int unsigned last_width, n_pulses, n_ev, k;
    int n_fail, tests_run, i, d;
    dpwe_top #(.PWRON_CYC(50), .STILL_CYC(2000), .HS_CYC(100)) dut (
        .aclk(aclk), .aresetn(aresetn), .sw_event(sw_event), .sw_dir_bwd(sw_dir_bwd),
        .sw_edge_first(sw_edge_first), .q_o(q_o), .q_oe(q_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    dpwe_tcu_model tcu (.aclk(aclk), .aresetn(aresetn), .q_o(q_o), .q_oe(q_oe),
        .line(line), .last_width(last_width), .n_pulses(n_pulses));
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tmo(input string nm);
        n_fail++;
        $display("[FAIL] %s expected answer seen none", nm);
        wrap_up();
    endtask
    // Expected width in cycles: kind 0 fwd, 1 bwd, 2 high speed, 3 stand-still
    function automatic logic [31:0] wexp(input int kd, input logic [1:0] s);
        int unsigned us;
        case (kd)
            0: us = (s == 2'b10) ? dpwe_pkg::T_FWD3_US : dpwe_pkg::T_FWD_US;
            1: us = s[1] ? (s[0] ? dpwe_pkg::T_BWD4_US : dpwe_pkg::T_BWD3_US)
                         : (s[0] ? dpwe_pkg::T_BWD2_US : dpwe_pkg::T_BWD1_US);
            2: us = s[0] ? dpwe_pkg::T_HS24_US : dpwe_pkg::T_HS13_US;
            default: us = dpwe_pkg::T_STILL_US;
        endcase
        return 32'(us * dpwe_pkg::CYC_PER_US);
    endfunction
    task automatic axw(input logic [3:0] a, input logic [31:0] dt, input logic [1:0] er);
        logic ta, tw, gb;
        logic [1:0] rs;
        @(posedge aclk);
        awaddr <= a;
        wdata <= dt;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int j = 0; j < 50; j++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            gb = bvalid === 1'b1;
            rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (gb) begin
                bready <= 1'b0;
                chk("bresp", 32'(rs), 32'(er));
                return;
            end
        end
        tmo("bvalid");
    endtask
    task automatic axr(input logic [3:0] a, input logic [1:0] er);
        logic ta, gr;
        logic [1:0] rs;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int j = 0; j < 50; j++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            gr = rvalid === 1'b1;
            rd = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (gr) begin
                rready <= 1'b0;
                chk("rresp", 32'(rs), 32'(er));
                return;
            end
        end
        tmo("rvalid");
    endtask
    // Held long enough to pass the two-stage synchroniser
    task automatic ev(input logic first, input logic bwd);
        sw_edge_first <= first;
        sw_dir_bwd <= bwd;
        sw_event <= 1'b1;
        repeat (4) @(posedge aclk);
        sw_event <= 1'b0;
        repeat (4) @(posedge aclk);
        n_ev++;
    endtask
    task automatic pulse(input logic [31:0] exp, input string nm);
        int unsigned n0;
        n0 = n_pulses;
        for (int j = 0; j < 60000 && n_pulses == n0; j++) @(negedge aclk);
        @(posedge aclk);
        if (n_pulses == n0) tmo(nm);
        chk(nm, last_width, exp);
    endtask
    initial begin
        {aresetn, sw_event, sw_dir_bwd, sw_edge_first} = 4'h0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wstrb, wdata} = {12'h000, 4'hf, 32'h0};
        {n_fail, tests_run, n_ev} = 0;
        d = $urandom(59393);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(dpwe_pkg::ADDR_CTRL, 2'b00);
        chk("ctrl_rst", rd, 32'h07);
        axw(dpwe_pkg::ADDR_CTRL, 32'h05, 2'b00);
        axr(dpwe_pkg::ADDR_STAT, 2'b00);
        chk("in_pwron", rd & 32'h1, 32'h1);
        repeat (150) @(posedge aclk);
        chk("no_pwron_pulse", n_pulses, 0);
        ev(1'b1, 1'($urandom_range(1, 0)));
        repeat (300) @(posedge aclk);
        chk("first_supp", n_pulses, 0);
        ev(1'b0, 1'b0);
        pulse(wexp(0, 2'b01), "fwd2");
        axw(4'hc, 32'h1f, 2'b10);
        axr(4'hc, 2'b10);
        chk("unmapped", rd, 32'h0);
        axr(dpwe_pkg::ADDR_CTRL, 2'b00);
        chk("ctrl_kept", rd, 32'h05);
        axw(dpwe_pkg::ADDR_CTRL, 32'h07, 2'b00);
        d = $urandom_range(1, 0);
        ev(1'b0, 1'(d));
        pulse(wexp(d, 2'b11), "dir4");
        axw(dpwe_pkg::ADDR_CTRL, 32'h0c, 2'b00);
        k = n_pulses;
        ev(1'b0, 1'b0);
        // Events keep coming during the pulse so the next one sees fast spacing
        for (i = 0; i < 1000 && n_pulses == k; i++) begin
            ev(1'b0, 1'b0);
            repeat ($urandom_range(40, 5)) @(posedge aclk);
        end
        if (n_pulses == k) tmo("fwd1");
        chk("fwd1", last_width, wexp(0, 2'b00));
        ev(1'b0, 1'b0);
        pulse(wexp(2, 2'b00), "hs1");
        axw(dpwe_pkg::ADDR_CTRL, 32'h14, 2'b00);
        pulse(wexp(3, 2'b00), "still1");
        axw(dpwe_pkg::ADDR_CTRL, 32'h02, 2'b00);
        ev(1'b0, 1'b1);
        pulse(32'(dpwe_pkg::T_SPEED_US * dpwe_pkg::CYC_PER_US), "speed");
        axr(dpwe_pkg::ADDR_EVT, 2'b00);
        chk("evt_cnt", rd & 32'hffff, n_ev);
        chk("line_idle", 32'(line), 32'h1);
        // Mid-run reset, then set three before power-on ends
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axw(dpwe_pkg::ADDR_CTRL, 32'h06, 2'b00);
        pulse(32'(dpwe_pkg::T_PON3_US * dpwe_pkg::CYC_PER_US), "pon3");
        wrap_up();
    end
endmodule
